//--- design/ifeb_top.v
// Interrupt flag and enable bank with AHB-Lite register slave
`timescale 1ns/1ps
`include "ifeb_defs.vh"
module ifeb_top (
  // Clock, reset, enable
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        clk_en,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [11:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // Source requests
  input  wire        usb_req_pin,
  input  wire [15:0] en0_src_req,
  input  wire [15:0] en1_src_req,
  input  wire [15:0] en2_src_req,
  // Arbitration side
  output reg  [15:0] pend0,
  output reg  [15:0] pend1,
  output reg  [15:0] pend2,
  output reg         usb_pend,
  output reg  [2:0]  usb_prio,
  output reg  [15:0] ext_route_need,
  // Interrupt
  output reg         irq
);
  localparam ST_IDLE  = 2'b01;
  localparam ST_WRITE = 2'b10;

  reg  [1:0]  state;
  reg  [11:0] wr_addr;
  reg  [15:0] interrupt_flags_5;
  reg  [15:0] interrupt_enables_0;
  reg  [15:0] interrupt_enables_1;
  reg  [15:0] interrupt_enables_2;
  reg  [15:0] usb_enable;
  reg  [2:0]  usb_priority;
  reg  [15:0] irq_status;
  reg  [15:0] irq_mask;
  reg         usb_seen;
  reg  [15:0] rd_value;
  wire        usb_level;
  wire        usb_rise;
  wire        addr_ok;
  wire        stat_read;

  ifeb_sync u_usb_sync (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .clk_en    (clk_en),
    .async_in  (usb_req_pin),
    .level_out (usb_level)
  );

  function [15:0] gate;
    input [15:0] flags;
    input [15:0] enables;
    input [15:0] impl;
    begin
      gate = flags & enables & impl;
    end
  endfunction

  function [15:0] wmask;
    input [31:0] data;
    input [15:0] impl;
    begin
      wmask = data[15:0] & impl;
    end
  endfunction

  assign usb_rise  = usb_level & ~usb_seen;
  assign addr_ok   = hsel & hready & htrans[1];
  assign stat_read = addr_ok & ~hwrite & (haddr == `IFEB_ADDR_IRQ_STAT);

  // Read mux, unimplemented bits zero
  always @* begin
    case (haddr)
      `IFEB_ADDR_FLAGS5:   rd_value = interrupt_flags_5 & `IFEB_MASK_FLAGS5;
      `IFEB_ADDR_EN0:      rd_value = interrupt_enables_0 & `IFEB_MASK_EN0;
      `IFEB_ADDR_EN1:      rd_value = interrupt_enables_1 & `IFEB_MASK_EN1;
      `IFEB_ADDR_EN2:      rd_value = interrupt_enables_2 & `IFEB_MASK_EN2;
      `IFEB_ADDR_EN5:      rd_value = usb_enable & `IFEB_MASK_EN5;
      `IFEB_ADDR_PRIO:     rd_value = {13'h0000, usb_priority};
      `IFEB_ADDR_IRQ_STAT: rd_value = irq_status;
      `IFEB_ADDR_IRQ_MASK: rd_value = irq_mask;
      default:             rd_value = 16'h0000;
    endcase
  end

  // Bus slave and register file
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state               <= ST_IDLE;
      wr_addr             <= 12'h000;
      hrdata              <= 32'h0000_0000;
      hreadyout           <= 1'b1;
      hresp               <= 1'b0;
      interrupt_flags_5   <= `IFEB_RESET_VALUE;
      interrupt_enables_0 <= `IFEB_RESET_VALUE;
      interrupt_enables_1 <= `IFEB_RESET_VALUE;
      interrupt_enables_2 <= `IFEB_RESET_VALUE;
      usb_enable          <= `IFEB_RESET_VALUE;
      usb_priority        <= `IFEB_PRIO_RESET;
      irq_status          <= 16'h0000;
      irq_mask            <= 16'h0000;
      usb_seen            <= 1'b0;
    end else if (clk_en) begin
      usb_seen <= usb_level;
      hresp    <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (addr_ok && hwrite) begin
            state   <= ST_WRITE;
            wr_addr <= haddr;
          end
          if (addr_ok && !hwrite) begin
            hrdata <= {16'h0000, rd_value};
          end
        end
        ST_WRITE: begin
          state <= ST_IDLE;
          if (addr_ok && hwrite) begin
            state   <= ST_WRITE;
            wr_addr <= haddr;
          end
          if (addr_ok && !hwrite) begin
            hrdata <= {16'h0000, rd_value};
          end
          case (wr_addr)
            `IFEB_ADDR_EN0:      interrupt_enables_0 <= wmask(hwdata, `IFEB_MASK_EN0);
            `IFEB_ADDR_EN1:      interrupt_enables_1 <= wmask(hwdata, `IFEB_MASK_EN1);
            `IFEB_ADDR_EN2:      interrupt_enables_2 <= wmask(hwdata, `IFEB_MASK_EN2);
            `IFEB_ADDR_EN5:      usb_enable <= wmask(hwdata, `IFEB_MASK_EN5);
            `IFEB_ADDR_PRIO:     usb_priority <= hwdata[2:0];
            `IFEB_ADDR_IRQ_MASK: irq_mask <= wmask(hwdata, `IFEB_MASK_STAT);
            default: begin
            end
          endcase
        end
        default: state <= ST_IDLE;
      endcase
      // Flag: set wins over software write
      if (state == ST_WRITE && wr_addr == `IFEB_ADDR_FLAGS5) begin
        interrupt_flags_5 <= wmask(hwdata, `IFEB_MASK_FLAGS5) | (usb_rise ? `IFEB_MASK_FLAGS5 : 16'h0000);
      end else if (usb_rise) begin
        interrupt_flags_5[`IFEB_USB_BIT] <= 1'b1;
      end
      // Sticky status, read clears, new event wins
      irq_status <= (stat_read ? 16'h0000 : irq_status)
                  | {14'h0000, usb_rise, usb_pend};
    end
  end

  // Outputs to arbitration and interrupt
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend0          <= 16'h0000;
      pend1          <= 16'h0000;
      pend2          <= 16'h0000;
      usb_pend       <= 1'b0;
      usb_prio       <= 3'h0;
      ext_route_need <= 16'h0000;
      irq            <= 1'b0;
    end else if (clk_en) begin
      pend0    <= gate(en0_src_req, interrupt_enables_0, `IFEB_MASK_EN0);
      pend1    <= gate(en1_src_req, interrupt_enables_1, `IFEB_MASK_EN1);
      pend2    <= gate(en2_src_req, interrupt_enables_2, `IFEB_MASK_EN2);
      usb_pend <= interrupt_flags_5[`IFEB_USB_BIT] & usb_enable[`IFEB_USB_BIT]
                & (usb_priority != `IFEB_PRIO_OFF);
      usb_prio <= usb_priority;
      ext_route_need <= {2'b00, interrupt_enables_1[`IFEB_EXT2_BIT], 8'h00,
                         interrupt_enables_1[`IFEB_EXT1_BIT], 3'b000,
                         interrupt_enables_0[`IFEB_EXT0_BIT]};
      irq <= |(irq_status & irq_mask);
    end
  end
endmodule

//--- pkg/ifeb_defs.vh
// Register map, field layout, reset values and priority codes of the interrupt flag and enable bank
`ifndef IFEB_DEFS_VH
`define IFEB_DEFS_VH

// Byte addresses
`define IFEB_ADDR_FLAGS5   12'h000
`define IFEB_ADDR_EN0      12'h004
`define IFEB_ADDR_EN1      12'h008
`define IFEB_ADDR_EN2      12'h00C
`define IFEB_ADDR_EN5      12'h010
`define IFEB_ADDR_PRIO     12'h014
`define IFEB_ADDR_IRQ_STAT 12'h018
`define IFEB_ADDR_IRQ_MASK 12'h01C

// Implemented bit masks
`define IFEB_MASK_FLAGS5 16'h0040
`define IFEB_MASK_EN0    16'h3FEF
`define IFEB_MASK_EN1    16'hFE1F
`define IFEB_MASK_EN2    16'h22E3
`define IFEB_MASK_EN5    16'h0040
`define IFEB_MASK_PRIO   16'h0007
`define IFEB_MASK_STAT   16'h0003

// Field positions
`define IFEB_USB_BIT      6
`define IFEB_EXT0_BIT     0
`define IFEB_EXT1_BIT     4
`define IFEB_EXT2_BIT     13
`define IFEB_STAT_REQ     0
`define IFEB_STAT_SET     1

// Reset values and priority codes
`define IFEB_RESET_VALUE  16'h0000
`define IFEB_PRIO_RESET   3'h4
`define IFEB_PRIO_OFF     3'h0

`endif

//--- design/ifeb_sync.v
// Three-stage synchroniser with agreement filter for a pin-side request
`timescale 1ns/1ps
module ifeb_sync (
  // Clock, reset, enable
  input  wire hclk,
  input  wire hresetn,
  input  wire clk_en,
  // Data
  input  wire async_in,
  output reg  level_out
);
  reg stage1;
  reg stage2;
  reg stage3;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stage1    <= 1'b0;
      stage2    <= 1'b0;
      stage3    <= 1'b0;
      level_out <= 1'b0;
    end else if (clk_en) begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
      if (stage2 == stage3) begin
        level_out <= stage3;
      end
    end
  end
endmodule

//--- bench/ifeb_chk.sv
// Assertion checker for the interrupt flag and enable bank
`timescale 1ns/1ps
module ifeb_chk (
  input wire hclk, input wire hresetn, input wire clk_en, input wire hsel, input wire [11:0] haddr,
  input wire [1:0] htrans, input wire hwrite, input wire [31:0] hwdata, input wire hready,
  input wire [31:0] hrdata, input wire [15:0] en0_src_req, input wire [15:0] pend0, input wire [15:0] pend1,
  input wire [15:0] pend2, input wire usb_pend, input wire [2:0] usb_prio, input wire [15:0] ext_route_need,
  input wire irq
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence en0_clear_wr;
    clk_en && hsel && hready && htrans[1] && hwrite && haddr == 12'h004 ##1 hwdata[15:0] == 16'h0000;
  endsequence
  upper_zero_a: assert property (hrdata[31:16] == 16'h0000) else $error("upper half set");
  pend0_impl_a: assert property ((pend0 & 16'hC010) == 16'h0000) else $error("pend0 bad bit");
  pend1_impl_a: assert property ((pend1 & 16'h01E0) == 16'h0000) else $error("pend1 bad bit");
  pend2_impl_a: assert property ((pend2 & 16'hDD1C) == 16'h0000) else $error("pend2 bad bit");
  route_bits_a: assert property ((ext_route_need & 16'hDFEE) == 16'h0000) else $error("route bad");
  pend_req_a: assert property ($past(clk_en) |-> (pend0 & ~$past(en0_src_req)) == 16'h0000)
    else $error("pend without flag");
  en_gate_a: assert property (en0_clear_wr |-> ##2 pend0 == 16'h0000) else $error("gate open");
  prio_off_a: assert property (usb_pend && $stable(usb_prio) |-> usb_prio != 3'h0)
    else $error("pend at priority zero");
  rst_quiet_a: assert property ($rose(hresetn) |-> !irq && !usb_pend && pend0 == 16'h0000)
    else $error("not quiet after reset");
endmodule
bind ifeb_top ifeb_chk u_chk (.hclk, .hresetn, .clk_en, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .hrdata, .en0_src_req, .pend0, .pend1, .pend2, .usb_pend, .usb_prio, .ext_route_need, .irq);

//--- bench/ifeb_src.sv
// Source model driving request levels and the USB pin
`timescale 1ns/1ps
module ifeb_src (
  // Clock
  input  wire         hclk,
  // Requests
  output logic        usb_req_pin,
  output logic [15:0] req0, output logic [15:0] req1, output logic [15:0] req2
);
  initial {usb_req_pin, req0, req1, req2} = 49'h0;
  task drive(input logic u, input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
    @(posedge hclk);
    usb_req_pin <= u;
    {req0, req1, req2} <= {a, b, c};
  endtask
endmodule

//--- bench/tb_top.sv
// Self-checking testbench of the interrupt flag and enable bank
`timescale 1ns/1ps
module tb_top;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b1, hwrite = 1'b0, clk_en = 1'b1;
  logic [11:0] haddr = 12'h000;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] hwdata = 32'h0, rd;
  wire         hready, usb_req_pin, hreadyout, hresp, usb_pend, irq;
  wire [31:0]  hrdata;
  wire [15:0]  q0, q1, q2, pend0, pend1, pend2, ext_route_need;
  wire [2:0]   usb_prio;
  logic [15:0] msk [5] = '{16'h0040, 16'h3FEF, 16'hFE1F, 16'h22E3, 16'h0040};
  int          n_fail = 0, check_count = 0, k;
  always #2.5 hclk = ~hclk;
  assign hready = hreadyout;
  ifeb_src src (.hclk(hclk), .usb_req_pin(usb_req_pin), .req0(q0), .req1(q1), .req2(q2));
  ifeb_top dut (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .usb_req_pin(usb_req_pin), .en0_src_req(q0), .en1_src_req(q1), .en2_src_req(q2),
    .pend0(pend0), .pend1(pend1), .pend2(pend2), .usb_pend(usb_pend), .usb_prio(usb_prio),
    .ext_route_need(ext_route_need), .irq(irq));
  task close_out;
    $display("Checks %0d, failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %0t got %h want %h", $time, got, exp);
    end
  endtask
  task hw;
    k = 0;
    do begin @(posedge hclk); k++; end while (hready !== 1'b1 && k < 20);
    if (hready !== 1'b1) begin n_fail++; close_out; end
  endtask
  task ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hw;
    htrans <= 2'h0;
    hwdata <= d;
    hw;
    rd = hrdata;
  endtask
  task t_reset;
    chk({31'h0, irq}, 32'h0);
    chk({30'h0, hreadyout, hresp}, 32'h2);
    for (int i = 0; i < 5; i++) begin ahb(0, 12'(4 * i), 0); chk(rd, 32'h0); end
    ahb(0, 12'h014, 0);
    chk(rd, 32'h4);
    $display("reset values done");
  endtask
  task t_rw;
    for (int i = 0; i < 5; i++) begin
      ahb(1, 12'(4 * i), 32'hFFFFFFFF);
      ahb(0, 12'(4 * i), 0);
      chk(rd, {16'h0, msk[i]});
      ahb(1, 12'(4 * i), 0);
      ahb(0, 12'(4 * i), 0);
      chk(rd, 32'h0);
    end
    ahb(1, 12'h020, 32'hFFFFFFFF);
    ahb(0, 12'h020, 0);
    chk(rd, 32'h0);
    $display("read write done");
  endtask
  task t_gate;
    src.drive(0, 16'hFFFF, 16'hFFFF, 16'hFFFF);
    for (int i = 1; i < 4; i++) ahb(1, 12'(4 * i), 32'hFFFFFFFF);
    repeat (2) @(posedge hclk);
    chk({pend0, pend1}, 32'h3FEFFE1F);
    chk({pend2, ext_route_need}, 32'h22E32011);
    ahb(1, 12'h004, 32'h1);
    repeat (2) @(posedge hclk);
    chk({16'h0, pend0}, 32'h1);
    ahb(1, 12'h004, 0);
    src.drive(0, 16'hFFFF, 16'h0000, 16'hFFFF);
    repeat (2) @(posedge hclk);
    chk({pend0, pend1}, 32'h0);
    $display("gating done");
  endtask
  task t_usb;
    ahb(1, 12'h010, 32'h40);
    ahb(1, 12'h01C, 32'h3);
    src.drive(1, 0, 0, 0);
    k = 0;
    while (usb_pend !== 1'b1 && k < 20) begin @(posedge hclk); k++; end
    chk({31'h0, usb_pend}, 32'h1);
    chk({29'h0, usb_prio}, 32'h4);
    if (k == 20) close_out;
    ahb(0, 12'h000, 0);
    chk({rd[30:0], irq}, 32'h81);
    ahb(0, 12'h018, 0);
    chk(rd, 32'h3);
    ahb(1, 12'h01C, 0);
    repeat (2) @(posedge hclk);
    chk({31'h0, irq}, 32'h0);
    src.drive(0, 0, 0, 0);
    ahb(1, 12'h014, 0);
    repeat (2) @(posedge hclk);
    chk({31'h0, usb_pend}, 32'h0);
    ahb(1, 12'h000, 0);
    ahb(0, 12'h018, 0);
    ahb(0, 12'h018, 0);
    ahb(1, 12'h01C, 32'h3);
    repeat (2) @(posedge hclk);
    chk({rd[30:0], irq}, 32'h0);
    $display("usb flag done");
  endtask
  task t_freeze;
    clk_en <= 1'b0;
    ahb(1, 12'h004, 32'hFFFFFFFF);
    @(posedge hclk);
    clk_en <= 1'b1;
    ahb(0, 12'h004, 0);
    chk(rd, 32'h0);
    $display("freeze done");
  endtask
  task t_rst2;
    ahb(1, 12'h008, 32'hFFFFFFFF);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    chk({hresp, irq, usb_pend, 13'h0, pend1}, 32'h0);
    ahb(0, 12'h008, 0);
    chk(rd, 32'h0);
    $display("mid reset done");
  endtask
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_rw;
    t_gate;
    t_usb;
    t_freeze;
    t_rst2;
    close_out;
  end
endmodule
